/* File: hdl/end_trig_conditioner.sv */
// Purpose: end trigger conditioner for one line-scan channel
// Assumes: trigger pins synchronous-safe after two flops, line strobe one cycle
// Notes: registers over a plain strobe port, read data one cycle later
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ns
`include "end_trig_params.svh"
module end_trig_conditioner
    import end_trig_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [`ET_ADDR_W-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic [3:0] enhanced_port_i,
    input wire logic [1:0] galvanic_port_i,
    input wire logic [1:0] lvds_port_i,
    input wire logic [1:0] pair_input_i,
    input wire logic [3:0] sense_input_i,
    input wire logic unbounded_page_acquisition_i,
    input wire logic line_captured_i,
    output logic end_take_next_o,
    output logic end_take_prior_o
);

    logic [`ET_CTRL_W-1:0] ctrl_q;
    logic [`ET_DELAY_W-1:0] delay_q;
    logic reject_q;
    logic [`ET_IN_W-1:0] meta_q;
    logic [`ET_IN_W-1:0] sync_q;
    logic sel_level;
    dly_state_t dly_q;
    logic [`ET_DELAY_W-1:0] remain_q;
    logic take_next_q;
    logic take_prior_q;
    logic [31:0] rdata_q;
    logic src_en;
    style_t style;
    port_sel_t port;
    polarity_t pol;
    strength_t strength;
    effect_t effect;
    logic ctrl_wr;
    logic ctrl_bad;
    logic active;
    logic fire;

    glitch_if gif ();

    // field views of the control word
    function automatic style_t f_style(input logic [`ET_CTRL_W-1:0] c);
        return style_t'(c[`ET_CTRL_STYLE_HI:`ET_CTRL_STYLE_LO]);
    endfunction

    function automatic strength_t f_strength(input logic [`ET_CTRL_W-1:0] c);
        return strength_t'(c[`ET_CTRL_STR_HI:`ET_CTRL_STR_LO]);
    endfunction

    // galvanic styles may not run with the filter off
    function automatic logic f_bad(input logic [`ET_CTRL_W-1:0] c);
        return (f_style(c) == galvanic_ttl_style || f_style(c) == galvanic_cmos_style)
            && f_strength(c) == strength_off;
    endfunction

    // port number to index; out of range falls back to the style default
    function automatic logic [1:0] f_index(input port_sel_t p, input int unsigned n,
                                           input logic [1:0] dflt);
        logic [1:0] idx;
        idx = dflt;
        if (p != default_port && 32'(p) <= n) begin
            idx = 2'(32'(p) - 1);
        end
        return idx;
    endfunction

    assign style = f_style(ctrl_q);
    assign strength = f_strength(ctrl_q);
    assign port = port_sel_t'(ctrl_q[`ET_CTRL_PORT_HI:`ET_CTRL_PORT_LO]);
    assign pol = polarity_t'(ctrl_q[`ET_CTRL_POL]);
    assign effect = effect_t'(ctrl_q[`ET_CTRL_EFF]);
    assign src_en = ctrl_q[`ET_CTRL_SRC];
    assign active = src_en && unbounded_page_acquisition_i;

    assign ctrl_wr = wr_i && addr_i == `ET_ADDR_CTRL;
    assign ctrl_bad = f_bad(wdata_i[`ET_CTRL_W-1:0]);

    // control word; a bad combination leaves the old word in place
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_q <= `ET_CTRL_RST;
        end else if (ctrl_wr && !ctrl_bad) begin
            ctrl_q <= wdata_i[`ET_CTRL_W-1:0];
        end
    end

    // sticky reject flag, set beats clear
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reject_q <= 1'b0;
        end else if (ctrl_wr && ctrl_bad) begin
            reject_q <= 1'b1;
        end else if (wr_i && addr_i == `ET_ADDR_STATUS && wdata_i[`ET_STAT_REJECT]) begin
            reject_q <= 1'b0;
        end
    end

    // line delay, clamped to the top of the range
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            delay_q <= `ET_DELAY_RST;
        end else if (wr_i && addr_i == `ET_ADDR_DELAY) begin
            if (wdata_i[`ET_DELAY_W-1:0] > `ET_DELAY_MAX) begin
                delay_q <= `ET_DELAY_MAX;
            end else begin
                delay_q <= wdata_i[`ET_DELAY_W-1:0];
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= {sense_input_i, pair_input_i, lvds_port_i, galvanic_port_i,
                       enhanced_port_i};
            sync_q <= meta_q;
        end
    end

    // source multiplexer, first stage of the chain
    always_comb begin
        sel_level = 1'b0;
        unique case (style)
            style_enhanced_ttl: sel_level = sync_q[`ET_IN_ENH + f_index(port, 4, 2'h0)];
            // galvanic and lvds, default port one
            galvanic_ttl_style,
            galvanic_cmos_style: sel_level = sync_q[`ET_IN_GALV + f_index(port, 2, 2'h0)];
            style_lvds: sel_level = sync_q[`ET_IN_LVDS + f_index(port, 2, 2'h0)];
            // pair and sense default to input two
            style_pair: sel_level = sync_q[`ET_IN_PAIR + f_index(port, 2, 2'h1)];
            style_sense: sel_level = sync_q[`ET_IN_SENSE + f_index(port, 4, 2'h1)];
            default: sel_level = 1'b0;
        endcase
    end

    // filter settings toward the edge and filter stages
    always_comb begin
        gif.level = sel_level;
        gif.rising = (pol == rising_select);
        gif.bypass = (style == style_sense);
        unique case (strength)
            strength_off: gif.hold_cycles = `ET_HOLD_W'(`ET_CYC(`ET_TC_OFF_NS));
            strength_strong: gif.hold_cycles = `ET_HOLD_W'(`ET_CYC(`ET_TC_STRONG_NS));
            default: gif.hold_cycles = `ET_HOLD_W'(`ET_CYC(`ET_TC_MED_NS));
        endcase
    end

    end_trig_filter u_filter (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .f(gif.filter)
    );

    // one end request at a time; later events are dropped until it is issued
    // a source lost in the cycle of the last counted line must not still fire
    assign fire = (dly_q == dly_idle && gif.event_p && active && delay_q == '0)
        || (dly_q == dly_wait && active && line_captured_i && remain_q == `ET_DELAY_W'(1));

    // delay line; counts captured line strobes only
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dly_q <= dly_idle;
            remain_q <= '0;
        end else begin
            unique case (dly_q)
                dly_idle: begin
                    if (gif.event_p && active && delay_q != '0) begin
                        remain_q <= delay_q;
                        dly_q <= dly_wait;
                    end
                end
                dly_wait: begin
                    // leaving the pin source drops a pending request
                    if (!active) begin
                        dly_q <= dly_idle;
                        remain_q <= '0;
                    end else if (line_captured_i) begin
                        remain_q <= remain_q - `ET_DELAY_W'(1);
                        if (remain_q == `ET_DELAY_W'(1)) begin
                            dly_q <= dly_idle;
                        end
                    end
                end
                default: dly_q <= dly_idle;
            endcase
        end
    end

    // next-line request; prior-line request; single pulse
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            take_next_q <= 1'b0;
            take_prior_q <= 1'b0;
        end else begin
            take_next_q <= fire && effect == take_next_line;
            take_prior_q <= fire && effect == take_prior_line;
        end
    end

    assign end_take_next_o = take_next_q;
    assign end_take_prior_o = take_prior_q;

    // read data one cycle after the strobe, zero elsewhere
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= '0;
            if (rd_i) begin
                unique case (addr_i)
                    `ET_ADDR_CTRL: rdata_q <= 32'(ctrl_q);
                    `ET_ADDR_DELAY: rdata_q <= 32'(delay_q);
                    `ET_ADDR_STATUS: begin
                        rdata_q[`ET_STAT_LEVEL] <= sel_level;
                        rdata_q[`ET_STAT_PEND] <= (dly_q == dly_wait);
                        rdata_q[`ET_STAT_REJECT] <= reject_q;
                        rdata_q[`ET_STAT_REM_LO +: `ET_DELAY_W] <= remain_q;
                    end
                    default: rdata_q <= '0;
                endcase
            end
        end
    end

    assign rdata_o = rdata_q;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    // steps of the delay line, shared by the properties below
    sequence delay_last_line;
        dly_q == dly_wait && active && line_captured_i && remain_q == `ET_DELAY_W'(1);
    endsequence

    sequence zero_delay_event;
        dly_q == dly_idle && gif.event_p && active && delay_q == '0;
    endsequence

    sequence delay_arm;
        dly_q == dly_idle && gif.event_p && active && delay_q != '0;
    endsequence

    sequence delay_mid_line;
        dly_q == dly_wait && active && line_captured_i && remain_q != `ET_DELAY_W'(1);
    endsequence

    sequence delay_cut;
        dly_q == dly_wait && !active;
    endsequence

    AST_NO_REQ_WITHOUT_SOURCE: assert property (
        (end_take_next_o || end_take_prior_o) |-> $past(active))
        else $error("end request while pin source off");

    AST_ZERO_DELAY_REQ: assert property (
        zero_delay_event |=> (end_take_next_o || end_take_prior_o))
        else $error("zero delay event not requested next cycle");

    AST_DELAY_EXPIRES: assert property (
        delay_last_line |=> (end_take_next_o || end_take_prior_o) && dly_q == dly_idle)
        else $error("delay expiry missed");

    AST_SINGLE_PULSE: assert property (
        (end_take_next_o || end_take_prior_o) |=> !(end_take_next_o || end_take_prior_o))
        else $error("end request longer than one cycle");

    AST_EFFECT_MATCH: assert property (
        end_take_prior_o |-> !end_take_next_o && $past(effect) == take_prior_line)
        else $error("prior-line request with wrong effect");

    AST_NEXT_MATCH: assert property (
        end_take_next_o |-> $past(effect) == take_next_line)
        else $error("next-line request with wrong effect");

    AST_DELAY_ARM: assert property (
        delay_arm |=> dly_q == dly_wait && remain_q == $past(delay_q))
        else $error("line delay not loaded on event");

    AST_LINE_COUNTS: assert property (
        delay_mid_line |=> remain_q == $past(remain_q) - `ET_DELAY_W'(1))
        else $error("captured line not counted");

    AST_CUT_CANCELS: assert property (
        delay_cut |=> dly_q == dly_idle && !(end_take_next_o || end_take_prior_o))
        else $error("pending end survived loss of source");

    AST_OFF_STAYS_IDLE: assert property (
        !active |=> dly_q == dly_idle)
        else $error("delay line armed while source off");

    AST_REJECT_SET: assert property (
        ctrl_wr && ctrl_bad |=> reject_q && $stable(ctrl_q))
        else $error("rejected control word not flagged");

    AST_GALV_NOT_OFF: assert property (!f_bad(ctrl_q))
        else $error("filter off on galvanic port");

    AST_DELAY_RANGE: assert property (delay_q <= `ET_DELAY_MAX)
        else $error("line delay above range");

    AST_NO_COUNT_WITHOUT_LINE: assert property (
        dly_q == dly_wait && active && !line_captured_i |=> $stable(remain_q))
        else $error("delay moved without a captured line");

    AST_RESET_DEFAULTS: assert property (
        $rose(reset_n_i) |-> pol == falling_select && port == default_port
        && strength == strength_strong)
        else $error("wrong control defaults after reset");

endmodule // end_trig_conditioner

/* File: hdl/end_trig_params.svh */
// Purpose: constants for the end trigger conditioner
// Assumes: 20 MHz channel clock, byte addressed register port
// Notes: definitions only
`ifndef END_TRIG_PARAMS_SVH
`define END_TRIG_PARAMS_SVH

// register byte addresses
`define ET_ADDR_W 8
`define ET_ADDR_CTRL 8'h00
`define ET_ADDR_DELAY 8'h04
`define ET_ADDR_STATUS 8'h08

// control word layout
`define ET_CTRL_SRC 0
`define ET_CTRL_STYLE_LO 1
`define ET_CTRL_STYLE_HI 3
`define ET_CTRL_PORT_LO 4
`define ET_CTRL_PORT_HI 6
`define ET_CTRL_POL 7
`define ET_CTRL_STR_LO 8
`define ET_CTRL_STR_HI 9
`define ET_CTRL_EFF 10
`define ET_CTRL_W 11
// source off, enhanced ttl, default port, falling, strong, next line
`define ET_CTRL_RST 11'h200

// status word layout
`define ET_STAT_LEVEL 0
`define ET_STAT_PEND 1
`define ET_STAT_REJECT 2
`define ET_STAT_REM_LO 16

// line delay
`define ET_DELAY_W 16
`define ET_DELAY_RST 16'h0000
`define ET_DELAY_MAX 16'hFFFE

// input vector layout after concatenation
`define ET_IN_W 14
`define ET_IN_ENH 0
`define ET_IN_GALV 4
`define ET_IN_LVDS 6
`define ET_IN_PAIR 8
`define ET_IN_SENSE 10

// filter time constants and clock period in ns
`define ET_CLK_NS 50
`define ET_TC_OFF_NS 100
`define ET_TC_MED_NS 500
`define ET_TC_STRONG_NS 2500
`define ET_HOLD_W 6
// least times round up to whole cycles
`define ET_CYC(ns) (((ns) + `ET_CLK_NS - 1) / `ET_CLK_NS)

`endif

/* File: hdl/end_trig_pkg.sv */
// Purpose: types for the end trigger conditioner
// Assumes: used with end_trig_params.svh
// Notes: enum codes are the control field encodings, apart from the two state types
package end_trig_pkg;

    typedef enum logic [2:0] {
        style_enhanced_ttl = 3'h0,
        galvanic_ttl_style = 3'h1,
        galvanic_cmos_style = 3'h2,
        style_lvds = 3'h3,
        style_pair = 3'h4,
        style_sense = 3'h5
    } style_t;

    typedef enum logic [2:0] {
        default_port = 3'h0,
        port_one = 3'h1,
        port_two = 3'h2,
        port_three = 3'h3,
        port_four = 3'h4
    } port_sel_t;

    typedef enum logic {
        falling_select = 1'b0,
        rising_select = 1'b1
    } polarity_t;

    typedef enum logic [1:0] {
        strength_off = 2'h0,
        strength_medium = 2'h1,
        strength_strong = 2'h2,
        strength_on = 2'h3
    } strength_t;

    typedef enum logic {
        take_next_line = 1'b0,
        take_prior_line = 1'b1
    } effect_t;

    typedef enum logic [1:0] {
        dly_idle = 2'b00,
        dly_wait = 2'b01
    } dly_state_t;

    typedef enum logic {
        filt_idle = 1'b0,
        filt_hold = 1'b1
    } filt_state_t;

endpackage

/* File: hdl/glitch_if.sv */
// Purpose: carrier between the conditioner and its glitch filter
// Assumes: single clock domain
// Notes: level and settings in, qualified event out
`timescale 1ns/1ns
`include "end_trig_params.svh"
interface glitch_if;
    logic level;
    logic rising;
    logic bypass;
    logic [`ET_HOLD_W-1:0] hold_cycles;
    logic event_p;
    modport ctrl (output level, output rising, output bypass, output hold_cycles,
                  input event_p);
    modport filter (input level, input rising, input bypass, input hold_cycles,
                    output event_p);
endinterface

/* File: hdl/end_trig_filter.sv */
// Purpose: edge detector and glitch filter of the end trigger chain
// Assumes: level already synchronised to clk_i
// Notes: event is one cycle, registered
`timescale 1ns/1ns
`include "end_trig_params.svh"
module end_trig_filter
    import end_trig_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    glitch_if.filter f
);

    logic prev_q;
    logic cand;
    filt_state_t state_q;
    logic [`ET_HOLD_W-1:0] cnt_q;
    logic event_q;

    // edge detection on the chosen transition
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= f.level;
        end
    end

    assign cand = (f.level != prev_q) && (f.level == f.rising);

    // hold new level for the time constant
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= filt_idle;
            cnt_q <= '0;
            event_q <= 1'b0;
        end else begin
            event_q <= 1'b0;
            unique case (state_q)
                filt_idle: begin
                    if (cand) begin
                        if (f.bypass) begin
                            event_q <= 1'b1;
                        end else begin
                            cnt_q <= `ET_HOLD_W'(1);
                            state_q <= filt_hold;
                        end
                    end
                end
                filt_hold: begin
                    // a pulse that ends early is dropped, it never re-arms mid-count
                    if (f.level != f.rising) begin
                        state_q <= filt_idle;
                    end else if (cnt_q + `ET_HOLD_W'(1) >= f.hold_cycles) begin
                        event_q <= 1'b1;
                        state_q <= filt_idle;
                    end else begin
                        cnt_q <= cnt_q + `ET_HOLD_W'(1);
                    end
                end
            endcase
        end
    end

    assign f.event_p = event_q;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence one_cycle_glitch;
        cand && !f.bypass ##1 (f.level != f.rising);
    endsequence

    AST_GLITCH_DROPPED: assert property (one_cycle_glitch |=> !event_q)
        else $error("short pulse passed the filter");

    AST_BYPASS_IMMEDIATE: assert property (
        state_q == filt_idle && cand && f.bypass |=> event_q)
        else $error("bypassed edge not passed next cycle");

    AST_EVENT_ON_LEVEL: assert property (event_q |-> $past(f.level) == $past(f.rising))
        else $error("event on wrong level");

endmodule // end_trig_filter

/* File: bench/end_trig_detector.sv */
// Purpose: model of the external end trigger detector
// Assumes: the bench asks for one pulse at a time
// Notes: pins rest at the inactive level of the chosen polarity
`timescale 1ns/1ns
module end_trig_detector (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic fire_i,
    input wire logic [3:0] pin_i,
    input wire logic [7:0] width_i,
    input wire logic active_high_i,
    output logic [13:0] pins_o
);
    logic [7:0] left_q;
    logic [3:0] pin_q;

    // pulse length is whatever the bench asks, narrow ones included
    // commanded pulse width
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            left_q <= 8'h00;
            pin_q <= 4'h0;
        end else if (fire_i) begin
            left_q <= width_i;
            pin_q <= pin_i;
        end else if (left_q != 8'h00) begin
            left_q <= left_q - 8'h01;
        end
    end

    // active level only while the pulse lasts
    always_comb begin
        pins_o = {14{~active_high_i}};
        if (left_q != 8'h00) begin
            pins_o[pin_q] = active_high_i;
        end
    end
endmodule // end_trig_detector

/* File: bench/end_trigger_conditioner_tb_top.sv */
// Purpose: self-checking bench for the end trigger conditioner
// Assumes: 20 MHz clock, detector model on the trigger pins
// Notes: notes queued by the drivers, checked by one monitor
`timescale 1ns/1ns
`include "end_trig_params.svh"
module end_trigger_conditioner_tb_top
    import end_trig_pkg::*;
();
    typedef struct {int lo; int hi; logic [31:0] val; logic [31:0] mask;} note_t;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h00000000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [31:0] rdata_o;
    logic fire_i = 1'b0;
    logic [3:0] pin_i = 4'h0;
    logic [7:0] width_i = 8'h00;
    logic active_high_i = 1'b0;
    logic [13:0] pins;
    logic unbounded_i = 1'b0;
    logic line_captured_i = 1'b0;
    logic end_take_next_o;
    logic end_take_prior_o;
    logic rd_d = 1'b0;
    int cyc = 0;
    int errors = 0;
    int tests_run = 0;
    int seed;
    int i;
    int n;
    int w;
    note_t rq[$];
    note_t pq[$];
    note_t e;
    note_t got;
    // style, port code, pin index of each selection case
    logic [9:0] ports_tbl [16] = '{
        {3'h0, 3'h0, 4'h0}, {3'h0, 3'h1, 4'h0}, {3'h0, 3'h2, 4'h1}, {3'h0, 3'h3, 4'h2},
        {3'h0, 3'h4, 4'h3}, {3'h1, 3'h0, 4'h4}, {3'h2, 3'h2, 4'h5}, {3'h3, 3'h0, 4'h6},
        {3'h3, 3'h2, 4'h7}, {3'h4, 3'h0, 4'h9}, {3'h4, 3'h1, 4'h8}, {3'h5, 3'h0, 4'hB},
        {3'h5, 3'h1, 4'hA}, {3'h5, 3'h2, 4'hB}, {3'h5, 3'h3, 4'hC}, {3'h5, 3'h4, 4'hD}};

    end_trig_conditioner dut (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .enhanced_port_i(pins[3:0]), .galvanic_port_i(pins[5:4]), .lvds_port_i(pins[7:6]),
        .pair_input_i(pins[9:8]), .sense_input_i(pins[13:10]),
        .unbounded_page_acquisition_i(unbounded_i), .line_captured_i(line_captured_i),
        .end_take_next_o(end_take_next_o), .end_take_prior_o(end_take_prior_o));

    end_trig_detector det (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .fire_i(fire_i), .pin_i(pin_i),
        .width_i(width_i), .active_high_i(active_high_i), .pins_o(pins));

    // free-running 50 ns clock
    initial begin
        forever #25 clk_i = ~clk_i;
    end

    task automatic check(input logic [31:0] val, input logic [31:0] exp);
        tests_run++;
        if (val !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, val, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // monitor: read data one cycle after the strobe, end pulses whenever seen
    always @(posedge clk_i) begin
        cyc = cyc + 1;
        if (rd_d) begin
            got = rq.pop_front();
            check(rdata_o & got.mask, got.val & got.mask);
        end
        rd_d = rd_i;
        if (end_take_next_o !== 1'b0 || end_take_prior_o !== 1'b0) begin
            if (pq.size() == 0) begin
                check({30'h0, end_take_prior_o, end_take_next_o}, 32'h0);
            end else begin
                got = pq.pop_front();
                check({30'h0, end_take_prior_o, end_take_next_o}, got.val);
                check((cyc >= got.lo && cyc <= got.hi) ? 32'h1 : 32'h0, 32'h1);
            end
        end
        // a hang ends the run as a mismatch
        if (cyc > 12000) begin
            errors++;
            tally_and_finish();
        end
    end

    function automatic logic [31:0] cw(input logic [2:0] s, input logic [2:0] p,
                                       input logic pol, input logic [1:0] st, input logic ef);
        return {21'h0, ef, st, pol, p, s, 1'b1};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
        note_t r;
        r.lo = 0;
        r.hi = 0;
        r.val = x;
        r.mask = m;
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        rq.push_back(r);
        @(posedge clk_i);
        rd_i <= 1'b0;
    endtask

    // kind 0 means no end request may follow the pulse
    task automatic fire(input logic [3:0] pin, input int wd, input int nf, input logic [31:0] kind);
        note_t x;
        @(posedge clk_i);
        x.lo = cyc + nf + 2;
        x.hi = cyc + nf + 9;
        x.val = kind;
        x.mask = 32'hFFFFFFFF;
        fire_i <= 1'b1;
        pin_i <= pin;
        width_i <= wd[7:0];
        if (kind != 32'h0) begin
            pq.push_back(x);
        end
        @(posedge clk_i);
        fire_i <= 1'b0;
        repeat (wd + nf + 12) @(posedge clk_i);
    endtask

    task automatic line_pulse(input int gap);
        @(posedge clk_i);
        line_captured_i <= 1'b1;
        @(posedge clk_i);
        line_captured_i <= 1'b0;
        repeat (gap) @(posedge clk_i);
    endtask

    // main sequence
    initial begin
        seed = 50982;
        repeat (4) @(posedge clk_i);
        reset_n_i <= 1'b1;
        rd(`ET_ADDR_CTRL, 32'h00000200, 32'hFFFFFFFF);
        rd(`ET_ADDR_DELAY, 32'h0, 32'hFFFFFFFF);
        rd(`ET_ADDR_STATUS, 32'h0, 32'hFFFFFFFE);
        rd(8'h0C, 32'h0, 32'hFFFFFFFF);
        $display("test reset values done");
        active_high_i <= 1'b1;
        unbounded_i <= 1'b1;
        wr(`ET_ADDR_CTRL, cw(style_sense, default_port, rising_select, strength_strong,
                             take_next_line) & 32'hFFFFFFFE);
        fire(4'hB, 6, 1, 32'h0);
        $display("test source off done");
        for (i = 0; i < 16; i++) begin
            n = (ports_tbl[i][9:7] == 3'h5) ? 1 : 10;
            w = n + 2 + ($unsigned($random(seed)) % 8);
            wr(`ET_ADDR_CTRL, cw(ports_tbl[i][9:7], ports_tbl[i][6:4], rising_select,
                                 strength_medium, take_next_line));
            fire(ports_tbl[i][3:0] ^ 4'h1, w, n, 32'h0);
            fire(ports_tbl[i][3:0], w, n, 32'h1);
        end
        $display("test port selection done");
        wr(`ET_ADDR_CTRL, 32'h0);
        active_high_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        for (i = 0; i < 4; i++) begin
            n = (i == 0) ? 2 : ((i == 2) ? 50 : 10);
            wr(`ET_ADDR_CTRL, cw(style_pair, default_port, falling_select, i[1:0],
                                 take_next_line));
            fire(4'h9, n - 1, n, 32'h0);
            fire(4'h9, n + 3, n, 32'h1);
        end
        wr(`ET_ADDR_CTRL, cw(style_sense, default_port, falling_select, strength_strong,
                             take_next_line));
        fire(4'hB, 2, 1, 32'h1);
        wr(`ET_ADDR_CTRL, cw(style_sense, default_port, falling_select, strength_strong,
                             take_prior_line));
        fire(4'hB, 4, 1, 32'h2);
        $display("test filter and effect done");
        for (i = 1; i < 3; i++) begin
            wr(`ET_ADDR_CTRL, cw(i[2:0], default_port, falling_select, strength_off,
                                 take_next_line));
            rd(`ET_ADDR_CTRL, cw(style_sense, default_port, falling_select, strength_strong,
                                 take_prior_line), 32'hFFFFFFFF);
            rd(`ET_ADDR_STATUS, 32'h4, 32'h4);
            wr(`ET_ADDR_STATUS, 32'h4);
            rd(`ET_ADDR_STATUS, 32'h0, 32'h4);
        end
        $display("test reject done");
        wr(`ET_ADDR_DELAY, 32'h0000FFFF);
        rd(`ET_ADDR_DELAY, 32'h0000FFFE, 32'hFFFFFFFF);
        wr(`ET_ADDR_DELAY, 32'h3);
        wr(`ET_ADDR_CTRL, cw(style_sense, default_port, falling_select, strength_strong,
                             take_next_line));
        fire(4'hB, 4, 1, 32'h0);
        rd(`ET_ADDR_STATUS, 32'h00030002, 32'hFFFF0002);
        repeat (2) line_pulse(40);
        e.lo = cyc + 2;
        e.hi = cyc + 6;
        e.val = 32'h1;
        e.mask = 32'hFFFFFFFF;
        pq.push_back(e);
        line_pulse(20);
        rd(`ET_ADDR_STATUS, 32'h0, 32'h2);
        wr(`ET_ADDR_DELAY, 32'h1);
        fire(4'hB, 4, 1, 32'h0);
        // source lost in the very cycle of the last counted line
        @(posedge clk_i);
        unbounded_i <= 1'b0;
        line_captured_i <= 1'b1;
        @(posedge clk_i);
        line_captured_i <= 1'b0;
        repeat (3) line_pulse(3);
        rd(`ET_ADDR_STATUS, 32'h0, 32'h2);
        fire(4'hB, 4, 1, 32'h0);
        $display("test line delay done");
        repeat (10) @(posedge clk_i);
        check(pq.size(), 32'h0);
        tally_and_finish();
    end
endmodule // end_trigger_conditioner_tb_top
